// File: hdl/tas_pkg.sv
`default_nettype none
package tas_pkg;
	// part variants: how the switched supply behaves under alarm
	typedef enum logic [1:0] {
		TAS_VAR_KEEP  = 2'h0,
		TAS_VAR_HIZ   = 2'h1,
		TAS_VAR_GND   = 2'h2
	} tas_variant_t;

	// battery check threshold options
	typedef enum logic [1:0] {
		TAS_DET_2V3 = 2'h0,
		TAS_DET_2V5 = 2'h1,
		TAS_DET_3V2 = 2'h2
	} tas_det_t;

	// power-up battery check sequence
	typedef enum logic [2:0] {
		TAS_BC_WAIT = 3'h1,
		TAS_BC_LOAD = 3'h2,
		TAS_BC_DONE = 3'h4
	} tas_bc_t;

	localparam int  TAS_CLK_MHZ      = 200;
	localparam int  TAS_TREC_MS      = 200;
	localparam int  TAS_TREC_CYC     = TAS_TREC_MS * 1000 * TAS_CLK_MHZ;
	localparam int  TAS_LOAD_US      = 1;
	localparam int  TAS_LOAD_CYC     = TAS_LOAD_US * TAS_CLK_MHZ;
	localparam int  TAS_TMR_W        = 26;
	localparam int  TAS_LOAD_W       = 8;
	localparam logic TAS_RST_ALARM_N = 1'b1;
	localparam logic TAS_RST_RESET_N = 1'b0;
	localparam logic TAS_RST_BLOW_N  = 1'b1;
	localparam logic TAS_RST_PFO_N   = 1'b0;
endpackage : tas_pkg
`default_nettype wire

// File: hdl/tas_sync.sv
`default_nettype none
module tas_sync #(
	parameter int W = 1
) (
	// clock and reset
	input  wire logic         mclk,
	input  wire logic         rst_b,
	input  wire logic [W-1:0] rst_val,
	// data
	input  wire logic [W-1:0] d,
	output var  logic [W-1:0] q
);
	logic [W-1:0] meta;

	// flops clear to zero so the reset branch stays constant; rst_val not applied
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			meta <= '0;
			q    <= '0;
		end else begin
			meta <= d;
			q    <= meta;
		end
	end
endmodule : tas_sync
`default_nettype wire

// File: hdl/tas_rec_timer.sv
`default_nettype none
module tas_rec_timer #(
	parameter int TREC_CYC = 40000000
) (
	// clock and reset
	input  wire logic mclk,
	input  wire logic rst_b,
	// hold request and result
	input  wire logic hold,
	output var  logic busy
);
	logic [tas_pkg::TAS_TMR_W-1:0] count;
	logic [tas_pkg::TAS_TMR_W-1:0] next_count;
	localparam logic [tas_pkg::TAS_TMR_W-1:0] LAST = tas_pkg::TAS_TMR_W'(TREC_CYC - 1);

	wire done = (count == LAST);

	// count cleared while held, restarts only after release
	assign next_count = hold ? '0 : (done ? count : count + 1'b1);

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			count <= '0;
			busy  <= 1'b1;
		end else begin
			count <= next_count;
			busy  <= hold | ~done;
		end
	end
endmodule : tas_rec_timer
`default_nettype wire

// File: hdl/tas_supervisor.sv
`default_nettype none
module tas_supervisor #(
	parameter int TREC_CYC = tas_pkg::TAS_TREC_CYC
) (
	// clock and reset
	input  wire logic               mclk,
	input  wire logic               rst_b,
	// configuration straps
	input  wire tas_pkg::tas_variant_t variant,
	input  wire tas_pkg::tas_det_t  det_sel,
	// comparator results
	input  wire logic               int_above_upper,
	input  wire logic               int_below_lower,
	input  wire logic               main_below_reset,
	input  wire logic               main_below_switchover,
	input  wire logic               main_below_battery,
	input  wire logic               main_above_backup_switch,
	input  wire logic               powerfail_in_below,
	input  wire logic [2:0]         battery_below_det,
	// tamper inputs
	input  wire logic               tamper_in_hi_a,
	input  wire logic               tamper_in_hi_b,
	input  wire logic               tamper_in_lo_a,
	input  wire logic               tamper_in_lo_b,
	// manual reset
	input  wire logic               manual_reset_n,
	// outputs
	output var  logic               security_alarm_n,
	output var  logic               supply_source_ind,
	output var  logic               vout_from_main,
	output var  logic               vout_from_battery,
	output var  logic               vout_ground,
	output var  logic               battery_check_load,
	output var  logic               battery_low_n,
	output var  logic               reset_out_n,
	output var  logic               powerfail_out_n,
	output var  logic               powerup_done
);
	localparam int NS = 14;
	logic [NS-1:0] raw_in;
	logic [NS-1:0] syn;
	logic [NS-1:0] syn_rst;

	assign raw_in = {battery_below_det, powerfail_in_below, main_above_backup_switch,
		main_below_battery, main_below_switchover, main_below_reset, int_below_lower,
		int_above_upper, tamper_in_lo_b, tamper_in_lo_a, tamper_in_hi_b, tamper_in_hi_a};
	// idle levels for reference only: sync clears to zero, so a short false
	// tamper follows reset while reset_out_n is still low
	assign syn_rst = 14'h0003;

	tas_sync #(.W(NS)) u_sync (
		.mclk    (mclk),
		.rst_b   (rst_b),
		.rst_val (syn_rst),
		.d       (raw_in),
		.q       (syn)
	);

	wire s_hi_a  = syn[0];
	wire s_hi_b  = syn[1];
	wire s_lo_a  = syn[2];
	wire s_lo_b  = syn[3];
	wire s_upper = syn[4];
	wire s_lower = syn[5];
	wire s_mrst  = syn[6];
	wire s_msw   = syn[7];
	wire s_mbat  = syn[8];
	wire s_mso   = syn[9];
	wire s_pfi   = syn[10];
	wire [2:0] s_det = syn[13:11];

	logic mr_meta;
	logic mr_s;
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			mr_meta <= 1'b0;
			mr_s    <= 1'b0;
		end else begin
			mr_meta <= manual_reset_n;
			mr_s    <= mr_meta;
		end
	end

	// tamper decode
	wire tamper_hi = ~s_hi_a | ~s_hi_b;
	wire tamper_lo = s_lo_a | s_lo_b;
	wire tamper    = tamper_hi | tamper_lo;
	// voltage trips on whichever supply is internal; comparators already track it
	wire volt_trip = s_upper | s_lower;
	wire alarm     = tamper | volt_trip;

	// supply source selection with hysteresis
	logic on_battery;
	wire  go_battery = s_msw | s_mbat;
	wire  go_main    = s_mso;
	wire  next_on_battery = on_battery ? ~go_main : go_battery;

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			on_battery <= 1'b1;
		end else begin
			on_battery <= next_on_battery;
		end
	end

	// variant effect on supply output and indicator
	wire force_ind = alarm & (variant != tas_pkg::TAS_VAR_KEEP);
	wire next_ind  = force_ind | on_battery;
	wire kill_out  = alarm & (variant != tas_pkg::TAS_VAR_KEEP);
	wire next_from_main = ~on_battery & ~kill_out;
	wire next_from_bat  = on_battery & ~kill_out;
	wire next_gnd  = alarm & (variant == tas_pkg::TAS_VAR_GND);

	// reset generation
	wire rst_hold = s_mrst | ~mr_s;
	logic rec_busy;

	tas_rec_timer #(.TREC_CYC(TREC_CYC)) u_rec (
		.mclk  (mclk),
		.rst_b (rst_b),
		.hold  (rst_hold),
		.busy  (rec_busy)
	);

	// power-up battery check
	tas_pkg::tas_bc_t bc_state;
	tas_pkg::tas_bc_t next_bc_state;
	logic [tas_pkg::TAS_LOAD_W-1:0] load_cnt;
	logic [tas_pkg::TAS_LOAD_W-1:0] next_load_cnt;
	logic blow;
	logic next_blow;
	localparam logic [tas_pkg::TAS_LOAD_W-1:0] LOAD_LAST =
		tas_pkg::TAS_LOAD_W'(tas_pkg::TAS_LOAD_CYC - 1);

	function automatic logic det_pick(input logic [2:0] d, input tas_pkg::tas_det_t sel);
		logic r;
		r = 1'b0;
		unique case (sel)
			tas_pkg::TAS_DET_2V3: r = d[0];
			tas_pkg::TAS_DET_2V5: r = d[1];
			tas_pkg::TAS_DET_3V2: r = d[2];
			default:              r = 1'b0;
		endcase
		return r;
	endfunction : det_pick

	wire bat_below = det_pick(s_det, det_sel);

	always_comb begin
		next_bc_state = bc_state;
		next_load_cnt = load_cnt;
		next_blow     = blow;
		unique case (bc_state)
			tas_pkg::TAS_BC_WAIT: begin
				next_load_cnt = '0;
				if (!s_mrst) begin
					next_bc_state = tas_pkg::TAS_BC_LOAD;
				end
			end
			tas_pkg::TAS_BC_LOAD: begin
				next_load_cnt = load_cnt + 1'b1;
				if (s_mrst) begin
					next_bc_state = tas_pkg::TAS_BC_WAIT;
				end else if (load_cnt == LOAD_LAST) begin
					next_blow     = bat_below;
					next_bc_state = tas_pkg::TAS_BC_DONE;
				end
			end
			tas_pkg::TAS_BC_DONE: begin
				if (s_mrst) begin
					next_bc_state = tas_pkg::TAS_BC_WAIT;
				end
			end
			default: next_bc_state = tas_pkg::TAS_BC_WAIT;
		endcase
		if (s_mrst) begin
			next_blow = 1'b0;
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			bc_state <= tas_pkg::TAS_BC_WAIT;
			load_cnt <= '0;
			blow     <= 1'b0;
		end else begin
			bc_state <= next_bc_state;
			load_cnt <= next_load_cnt;
			blow     <= next_blow;
		end
	end

	// power-fail: comparator ignored while main is below switchover; output forced low
	wire next_pfo_n = ~(s_pfi | s_msw);

	// power-up done once reset released; alarm meaningless before
	wire next_pu_done = ~rec_busy;

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			security_alarm_n   <= tas_pkg::TAS_RST_ALARM_N;
			supply_source_ind  <= 1'b1;
			vout_from_main     <= 1'b0;
			vout_from_battery  <= 1'b1;
			vout_ground        <= 1'b0;
			battery_check_load <= 1'b0;
			battery_low_n      <= tas_pkg::TAS_RST_BLOW_N;
			reset_out_n        <= tas_pkg::TAS_RST_RESET_N;
			powerfail_out_n    <= tas_pkg::TAS_RST_PFO_N;
			powerup_done       <= 1'b0;
		end else begin
			security_alarm_n   <= ~alarm;
			supply_source_ind  <= next_ind;
			vout_from_main     <= next_from_main;
			vout_from_battery  <= next_from_bat;
			vout_ground        <= next_gnd;
			battery_check_load <= (next_bc_state == tas_pkg::TAS_BC_LOAD);
			battery_low_n      <= ~next_blow;
			reset_out_n        <= ~rec_busy;
			powerfail_out_n    <= next_pfo_n;
			powerup_done       <= next_pu_done;
		end
	end

	// tamper to alarm output: sync stages plus output flop
	sequence s_tamper_seen;
		(tamper_in_lo_a | tamper_in_lo_b | ~tamper_in_hi_a | ~tamper_in_hi_b) [*4];
	endsequence

	AST_TAMPER_ALARM: assert property (@(posedge mclk) disable iff (!rst_b)
		s_tamper_seen |-> !security_alarm_n)
		else $error("tamper held but alarm inactive");

	AST_VOLT_ALARM: assert property (@(posedge mclk) disable iff (!rst_b)
		(int_above_upper | int_below_lower) [*4] |-> !security_alarm_n)
		else $error("voltage trip held but alarm inactive");

	AST_ALARM_CLEAR: assert property (@(posedge mclk) disable iff (!rst_b)
		(!alarm) |=> security_alarm_n)
		else $error("alarm stayed active without a cause");

	AST_IND_FORCE: assert property (@(posedge mclk) disable iff (!rst_b)
		(alarm && variant != tas_pkg::TAS_VAR_KEEP) |=> supply_source_ind && !vout_from_main)
		else $error("alarm variant did not force indicator high");

	AST_IND_NORMAL: assert property (@(posedge mclk) disable iff (!rst_b)
		(variant == tas_pkg::TAS_VAR_KEEP) |=> (supply_source_ind == $past(on_battery)))
		else $error("indicator not following supply source");

	AST_GND: assert property (@(posedge mclk) disable iff (!rst_b)
		(alarm && variant == tas_pkg::TAS_VAR_GND) |=> vout_ground && !vout_from_battery)
		else $error("ground variant did not ground output");

	AST_RESET_HOLD: assert property (@(posedge mclk) disable iff (!rst_b)
		rst_hold |-> ##2 (!reset_out_n [*2]))
		else $error("reset released while held");

	AST_BLD_RELEASE: assert property (@(posedge mclk) disable iff (!rst_b)
		s_mrst |=> battery_low_n)
		else $error("battery low not released on main loss");

	AST_PFO: assert property (@(posedge mclk) disable iff (!rst_b)
		(s_pfi | s_msw) |=> !powerfail_out_n)
		else $error("power-fail output not low");

	AST_LOAD_ONLY_PU: assert property (@(posedge mclk) disable iff (!rst_b)
		battery_check_load |-> (bc_state == tas_pkg::TAS_BC_LOAD))
		else $error("battery load outside power-up");
endmodule : tas_supervisor
`default_nettype wire

// File: tb/tas_field_model.sv
`default_nettype none
module tas_field_model (
	// commands from the bench
	input  wire logic [3:0] tamper_open,
	input  wire logic       mr_press,
	// levels seen by the block
	output var  logic       tamper_in_hi_a,
	output var  logic       tamper_in_hi_b,
	output var  logic       tamper_in_lo_a,
	output var  logic       tamper_in_lo_b,
	output var  logic       manual_reset_n
);
	timeunit 1ns;
	timeprecision 1ps;
	// closed loops sit at their normal level; opening pulls the other way
	assign tamper_in_hi_a = ~tamper_open[0];
	assign tamper_in_lo_a = tamper_open[1];
	assign tamper_in_hi_b = ~tamper_open[2];
	assign tamper_in_lo_b = tamper_open[3];
	// switch to ground; pull-up keeps it high when released
	assign manual_reset_n = ~mr_press;
endmodule : tas_field_model
`default_nettype wire

// File: tb/tas_supervisor_bench.sv
`default_nettype none
module tas_supervisor_bench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int TREC = 20;
	logic mclk, rst_b, iau, ibl, mbr, mbs, mbb, mab, pfb;
	logic [2:0] bbd;
	logic [3:0] topen;
	logic mr_press;
	tas_pkg::tas_variant_t variant;
	tas_pkg::tas_det_t     det_sel;
	wire logic thia, thib, tloa, tlob, mrn;
	logic alarm_n, ind, vmain, vbat, vgnd, bload, blow_n, rst_n, pfo_n, pdone;
	int miscompares;
	int samples_checked;
	tas_field_model i_tas_field_model (.tamper_open(topen), .mr_press(mr_press),
		.tamper_in_hi_a(thia), .tamper_in_hi_b(thib), .tamper_in_lo_a(tloa),
		.tamper_in_lo_b(tlob), .manual_reset_n(mrn));
	tas_supervisor #(.TREC_CYC(TREC)) i_tas_supervisor (.mclk(mclk), .rst_b(rst_b),
		.variant(variant), .det_sel(det_sel), .int_above_upper(iau),
		.int_below_lower(ibl), .main_below_reset(mbr), .main_below_switchover(mbs),
		.main_below_battery(mbb), .main_above_backup_switch(mab),
		.powerfail_in_below(pfb), .battery_below_det(bbd), .tamper_in_hi_a(thia),
		.tamper_in_hi_b(thib), .tamper_in_lo_a(tloa), .tamper_in_lo_b(tlob),
		.manual_reset_n(mrn), .security_alarm_n(alarm_n), .supply_source_ind(ind),
		.vout_from_main(vmain), .vout_from_battery(vbat), .vout_ground(vgnd),
		.battery_check_load(bload), .battery_low_n(blow_n), .reset_out_n(rst_n),
		.powerfail_out_n(pfo_n), .powerup_done(pdone));
	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end
	task automatic step(input int n);
		repeat (n) @(negedge mclk);
	endtask : step
	task automatic chk(input logic got, input logic exp, input string what);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED %0t %s", $time, what);
		end
	endtask : chk
	task automatic end_sim;
		if (miscompares == 0 && samples_checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : end_sim
	// reset must be low early in the hold and released once it expires
	task automatic reset_span(input string what);
		step(10);
		chk(rst_n, 1'b0, what);
		chk(pdone, 1'b0, what);
		step(TREC + 10);
		chk(rst_n, 1'b1, what);
	endtask : reset_span
	initial begin
		#50us;
		miscompares++;
		end_sim();
	end
	initial begin
		{iau, ibl, mbr, mbs, mbb, pfb, mr_press} = '0;
		mab = 1'b1;
		bbd = 3'h2;
		topen = 4'h0;
		variant = tas_pkg::TAS_VAR_KEEP;
		det_sel = tas_pkg::TAS_DET_2V5;
		miscompares = 0;
		samples_checked = 0;
		rst_b = 1'b0;
		step(4);
		rst_b = 1'b1;
		reset_span("power-up reset");
		chk(pdone, 1'b1, "power-up done");
		chk(bload, 1'b1, "battery load");
		step(250);
		chk(bload, 1'b0, "battery load end");
		chk(blow_n, 1'b0, "battery low");
		// later battery recovery is not seen: check runs only at power-up
		bbd = 3'h0;
		step(20);
		chk(blow_n, 1'b0, "battery low kept");
		chk(bload, 1'b0, "no late load");
		mbr = 1'b1;
		step(4);
		chk(blow_n, 1'b1, "battery low release");
		chk(rst_n, 1'b0, "supply reset");
		step(TREC + 10);
		chk(rst_n, 1'b0, "reset held low");
		mbr = 1'b0;
		reset_span("supply return");
		mr_press = 1'b1;
		step(TREC + 10);
		chk(rst_n, 1'b0, "manual reset held");
		mr_press = 1'b0;
		reset_span("manual release");
		for (int i = 0; i < 4; i++) begin
			topen = 4'h1 << i;
			step(4);
			chk(alarm_n, 1'b0, "tamper alarm");
			topen = 4'h0;
			step(4);
			chk(alarm_n, 1'b1, "tamper clear");
		end
		for (int i = 0; i < 2; i++) begin
			{iau, ibl} = 2'h1 << i;
			step(4);
			chk(alarm_n, 1'b0, "voltage alarm");
			{iau, ibl} = 2'h0;
			step(4);
			chk(alarm_n, 1'b1, "voltage clear");
		end
		for (int v = 0; v < 3; v++) begin
			variant = tas_pkg::tas_variant_t'(v);
			topen = 4'h4;
			step(4);
			chk(ind, v != 0, "indicator under alarm");
			chk(vmain, v == 0, "output kept");
			chk(vgnd, v == 2, "output grounded");
			topen = 4'h0;
			step(4);
			chk(ind, 1'b0, "indicator on main");
			chk(vmain, 1'b1, "main restored");
		end
		variant = tas_pkg::TAS_VAR_KEEP;
		pfb = 1'b1;
		step(4);
		chk(pfo_n, 1'b0, "power-fail input");
		pfb = 1'b0;
		step(4);
		chk(pfo_n, 1'b1, "power-fail release");
		// both switchover causes; hysteresis keeps battery until backup level
		for (int i = 0; i < 2; i++) begin
			{mbs, mbb} = 2'h1 << i;
			mab = 1'b0;
			step(4);
			chk(ind, 1'b1, "battery indicator");
			chk(vbat, 1'b1, "battery feed");
			chk(pfo_n, mbb, "power-fail switchover");
			variant = i ? tas_pkg::TAS_VAR_GND : tas_pkg::TAS_VAR_KEEP;
			topen = 4'h8;
			step(4);
			chk(alarm_n, 1'b0, "alarm on battery");
			chk(vbat, i == 0, "battery feed under alarm");
			chk(vgnd, i == 1, "ground on battery");
			topen = 4'h0;
			{mbs, mbb} = 2'h0;
			step(4);
			chk(vbat, 1'b1, "hysteresis hold");
			mab = 1'b1;
			step(4);
			chk(vmain, 1'b1, "back to main");
			chk(ind, 1'b0, "main indicator");
		end
		end_sim();
	end
endmodule : tas_supervisor_bench
`default_nettype wire
